// File: core/rms_pkg.sv
// package: constants and types for the resolver mode sequencer
package rms_pkg;

    // ==========================================================
    // mode indicator bit positions (ascending order of modes)
    localparam int MODE_CAL_BIT = 0;
    localparam int MODE_CFG_BIT = 1;
    localparam int MODE_SET_BIT = 2;
    localparam int MODE_ALN_BIT = 3;
    localparam int MODE_MEAS_BIT = 4;
    localparam int MODE_BITS = 5;

    // ==========================================================
    // channel status bit positions
    localparam int CH_CAL_BIT = 0;
    localparam int CH_CFG_BIT = 1;
    localparam int CH_SET_BIT = 2;
    localparam int CH_ALN_BIT = 3;
    localparam int CH_MEAS_BIT = 4;
    localparam int CH_BITS = 5;

    // ==========================================================
    // factory defaults
    localparam logic [15:0] DEF_FULL_SCALE = 16'h0400;
    localparam logic DEF_DUAL_SEL = 1'b0;
    localparam logic [15:0] DEF_OFFSET = 16'h0000;

    // ==========================================================
    // timing: self check time and derived cycles at 20 MHz
    localparam int CLK_NS = 50;
    localparam int SELF_CHECK_NS = 1000;
    localparam int SELF_CHECK_CYC = (SELF_CHECK_NS + CLK_NS - 1) / CLK_NS;

    // ==========================================================
    // host commands
    localparam logic [2:0] CMD_CAL = 3'h0;
    localparam logic [2:0] CMD_CFG = 3'h1;
    localparam logic [2:0] CMD_SET = 3'h2;
    localparam logic [2:0] CMD_ALN = 3'h3;
    localparam logic [2:0] CMD_MEAS = 3'h4;
    localparam logic [2:0] CMD_EXIT = 3'h5;

    typedef enum logic [2:0] {
        RMS_CHECK,
        RMS_CH_STAT,
        RMS_MOD_STAT,
        RMS_INIT_DONE,
        RMS_IDLE,
        RMS_RUN
    } rms_state_e;

endpackage

// File: core/rms_sync3.sv
// three-stage synchroniser with agreement qualifier for pin inputs
`timescale 1ns/1ps
`default_nettype none

module rms_sync3 #(
    parameter int WIDTH = 5
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);

    if (WIDTH < 1)
    begin : g_width_check
        $error("rms_sync3: width must be positive");
    end

    // ==========================================================
    // first stage is read only by the second
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            level <= '0;
        end
        else if (ce)
        begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // change accepted only once second and third agree
            if (s2_q == s3_q)
            begin
                level <= s3_q;
            end
        end
    end

endmodule
`default_nettype wire

// File: core/rms_seq.sv
// power-up and mode sequencer for a two-channel resolver module
`timescale 1ns/1ps
`default_nettype none

// Function
// - power-up self check, validate stored mode data
// - channel status bits before module status bits
// - init flag set last, after status valid
// - stay idle until first host command
// - idle reports status only, data zeroed
// - data withheld until measurement command accepted
// - configuration change resets higher parameters, offsets
// - defaults: two single channels, 1024 counts
// - setup change resets alignment and position offsets
// - foreign dual setup clears alignment offset
// - measurement refused until re-aligned
// - stack address from five switches, off is zero
// - nonzero address disables network interface
// - hot-inserted module ignored until power-up
// - init flag cleared on first accepted command
// - mode exit enters highest valid mode
module rms_seq #(
    parameter int ADDR_W = 5
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] addr_sw,
    input wire logic has_net,
    input wire logic [1:0] nv_cal_ok,
    input wire logic [1:0] nv_cfg_ok,
    input wire logic [1:0] nv_set_ok,
    input wire logic nv_aln_ok,
    input wire logic selfcheck_ok,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic cfg_write,
    input wire logic set_write,
    input wire logic set_dual_foreign,
    input wire logic [15:0] set_full_scale,
    input wire logic align_done,
    input wire logic [1:0] meas_ch_en,
    input wire logic [15:0] pos_in0,
    input wire logic [15:0] pos_in1,
    input wire logic [15:0] vel_in0,
    input wire logic [15:0] vel_in1,
    output logic cmd_accept,
    output logic init_flag,
    output logic [4:0] mode_bits,
    output logic [4:0] ch0_status,
    output logic [4:0] ch1_status,
    output logic [15:0] pos_out0,
    output logic [15:0] pos_out1,
    output logic [15:0] vel_out0,
    output logic [15:0] vel_out1,
    output logic [ADDR_W-1:0] stack_addr,
    output logic net_enable,
    output logic dual_sel,
    output logic [15:0] full_scale,
    output logic [15:0] align_offset,
    output logic [15:0] pos_offset0,
    output logic [15:0] pos_offset1
);

    // address logic serves a five-switch selector only
    if (ADDR_W != 5)
    begin : g_width_check
        $error("rms_seq: switch width must be five");
    end

    // ==========================================================
    // switch synchroniser
    logic [ADDR_W-1:0] sw_lvl;

    rms_sync3 #(.WIDTH(ADDR_W)) u_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .pin(addr_sw),
        .level(sw_lvl)
    );

    // ==========================================================
    // power-up sequencer
    rms_pkg::rms_state_e state_q;
    logic [7:0] chk_cnt_q;
    logic cal_v_q;
    logic cfg_v_q;
    logic set_v_q;
    logic aln_v_q;
    logic meas_run_q;

    // highest mode whose prerequisite data is valid
    function automatic logic [4:0] best_mode(input logic c, input logic f,
                                             input logic s, input logic a);
        logic [4:0] m;
        m = '0;
        if (!c)
            m[rms_pkg::MODE_CAL_BIT] = 1'b1;
        else if (!f)
            m[rms_pkg::MODE_CFG_BIT] = 1'b1;
        else if (!s)
            m[rms_pkg::MODE_SET_BIT] = 1'b1;
        else if (!a)
            m[rms_pkg::MODE_ALN_BIT] = 1'b1;
        else
            m[rms_pkg::MODE_MEAS_BIT] = 1'b1;
        return m;
    endfunction

    wire take_cmd = ce && cmd_valid && (state_q == rms_pkg::RMS_IDLE
                                        || state_q == rms_pkg::RMS_RUN);
    wire meas_ok = cal_v_q && cfg_v_q && set_v_q && aln_v_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= rms_pkg::RMS_CHECK;
            chk_cnt_q <= 8'h00;
        end
        else if (ce)
        begin
            unique case (state_q)
                rms_pkg::RMS_CHECK:
                begin
                    chk_cnt_q <= chk_cnt_q + 8'h01;
                    if (chk_cnt_q == 8'(rms_pkg::SELF_CHECK_CYC - 1))
                    begin
                        state_q <= rms_pkg::RMS_CH_STAT;
                    end
                end
                rms_pkg::RMS_CH_STAT: state_q <= rms_pkg::RMS_MOD_STAT;
                rms_pkg::RMS_MOD_STAT: state_q <= rms_pkg::RMS_INIT_DONE;
                rms_pkg::RMS_INIT_DONE: state_q <= rms_pkg::RMS_IDLE;
                rms_pkg::RMS_IDLE:
                begin
                    if (take_cmd)
                    begin
                        state_q <= rms_pkg::RMS_RUN;
                    end
                end
                rms_pkg::RMS_RUN: state_q <= rms_pkg::RMS_RUN;
            endcase
        end
    end

    // ==========================================================
    // validity of stored data; self-check failure leaves all invalid
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cal_v_q <= 1'b0;
            cfg_v_q <= 1'b0;
            set_v_q <= 1'b0;
            aln_v_q <= 1'b0;
        end
        else if (ce)
        begin
            if (state_q == rms_pkg::RMS_CHECK && chk_cnt_q == 8'h00)
            begin
                cal_v_q <= selfcheck_ok && (&nv_cal_ok);
                cfg_v_q <= selfcheck_ok && (&nv_cfg_ok);
                set_v_q <= selfcheck_ok && (&nv_set_ok);
                aln_v_q <= selfcheck_ok && nv_aln_ok;
            end
            else if (state_q == rms_pkg::RMS_RUN)
            begin
                if (cfg_write)
                begin
                    cfg_v_q <= 1'b1;
                    set_v_q <= 1'b1; // defaults are a valid setup
                    aln_v_q <= 1'b1; // default single channels need no alignment
                end
                else if (set_write)
                begin
                    set_v_q <= 1'b1;
                    aln_v_q <= !set_dual_foreign;
                end
                else if (mode_bits[rms_pkg::MODE_ALN_BIT] && align_done)
                begin
                    aln_v_q <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // parameters and offsets with cascaded default restore
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            dual_sel <= rms_pkg::DEF_DUAL_SEL;
            full_scale <= rms_pkg::DEF_FULL_SCALE;
            align_offset <= rms_pkg::DEF_OFFSET;
            pos_offset0 <= rms_pkg::DEF_OFFSET;
            pos_offset1 <= rms_pkg::DEF_OFFSET;
        end
        else if (ce && state_q == rms_pkg::RMS_RUN)
        begin
            if (cfg_write)
            begin
                dual_sel <= rms_pkg::DEF_DUAL_SEL;
                full_scale <= rms_pkg::DEF_FULL_SCALE;
                align_offset <= rms_pkg::DEF_OFFSET;
                pos_offset0 <= rms_pkg::DEF_OFFSET;
                pos_offset1 <= rms_pkg::DEF_OFFSET;
            end
            else if (set_write)
            begin
                dual_sel <= set_dual_foreign;
                full_scale <= set_full_scale;
                align_offset <= rms_pkg::DEF_OFFSET;
                pos_offset0 <= rms_pkg::DEF_OFFSET;
                pos_offset1 <= rms_pkg::DEF_OFFSET;
            end
        end
    end

    // ==========================================================
    // status, mode indicators and init flag
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ch0_status <= '0;
            ch1_status <= '0;
            mode_bits <= '0;
            init_flag <= 1'b0;
            cmd_accept <= 1'b0;
            meas_run_q <= 1'b0;
        end
        else if (ce)
        begin
            cmd_accept <= take_cmd;
            if (state_q == rms_pkg::RMS_CH_STAT)
            begin
                ch0_status <= {1'b0, aln_v_q, nv_set_ok[0], nv_cfg_ok[0], nv_cal_ok[0]};
                ch1_status <= {1'b0, aln_v_q, nv_set_ok[1], nv_cfg_ok[1], nv_cal_ok[1]};
            end
            else if (state_q == rms_pkg::RMS_RUN)
            begin
                ch0_status <= {meas_run_q & meas_ch_en[0], aln_v_q, set_v_q, cfg_v_q, cal_v_q};
                ch1_status <= {meas_run_q & meas_ch_en[1], aln_v_q, set_v_q, cfg_v_q, cal_v_q};
            end
            if (state_q == rms_pkg::RMS_MOD_STAT)
            begin
                mode_bits <= best_mode(cal_v_q, cfg_v_q, set_v_q, aln_v_q);
            end
            if (state_q == rms_pkg::RMS_INIT_DONE)
            begin
                init_flag <= 1'b1;
            end
            else if (take_cmd)
            begin
                init_flag <= 1'b0;
            end
            if (take_cmd)
            begin
                meas_run_q <= 1'b0;
                unique case (cmd_code)
                    rms_pkg::CMD_CAL: mode_bits <= 5'h01;
                    rms_pkg::CMD_CFG: mode_bits <= cal_v_q ? 5'h02
                                                  : best_mode(cal_v_q, cfg_v_q, set_v_q, aln_v_q);
                    rms_pkg::CMD_SET: mode_bits <= (cal_v_q && cfg_v_q) ? 5'h04
                                                  : best_mode(cal_v_q, cfg_v_q, set_v_q, aln_v_q);
                    rms_pkg::CMD_ALN: mode_bits <= (cal_v_q && cfg_v_q && set_v_q) ? 5'h08
                                                  : best_mode(cal_v_q, cfg_v_q, set_v_q, aln_v_q);
                    rms_pkg::CMD_MEAS:
                    begin
                        mode_bits <= best_mode(cal_v_q, cfg_v_q, set_v_q, aln_v_q);
                        meas_run_q <= meas_ok;
                    end
                    default: mode_bits <= best_mode(cal_v_q, cfg_v_q, set_v_q, aln_v_q);
                endcase
            end
            else if (state_q == rms_pkg::RMS_RUN && !meas_ok && meas_run_q)
            begin
                meas_run_q <= 1'b0;
                mode_bits <= best_mode(cal_v_q, cfg_v_q, set_v_q, aln_v_q);
            end
        end
    end

    // ==========================================================
    // position and velocity words, zero unless measuring
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pos_out0 <= '0;
            pos_out1 <= '0;
            vel_out0 <= '0;
            vel_out1 <= '0;
        end
        else if (ce)
        begin
            pos_out0 <= (meas_run_q && meas_ch_en[0]) ? pos_in0 : 16'h0000;
            pos_out1 <= (meas_run_q && meas_ch_en[1]) ? pos_in1 : 16'h0000;
            vel_out0 <= (meas_run_q && meas_ch_en[0]) ? vel_in0 : 16'h0000;
            vel_out1 <= (meas_run_q && meas_ch_en[1]) ? vel_in1 : 16'h0000;
        end
    end

    // ==========================================================
    // stack address latched once after power-up; later changes and
    // hot insertion are ignored until the next reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stack_addr <= '0;
            net_enable <= 1'b0;
        end
        else if (ce && state_q == rms_pkg::RMS_MOD_STAT)
        begin
            stack_addr <= sw_lvl;
            net_enable <= has_net && (sw_lvl == '0);
        end
    end

    // ==========================================================
    // checks
    a_init_last: assert property (@(posedge clk) disable iff (rst)
        $rose(init_flag) |-> $past(state_q) == rms_pkg::RMS_INIT_DONE && mode_bits != '0)
        else $error("init flag rose out of order");

    a_idle_zero: assert property (@(posedge clk) disable iff (rst)
        init_flag |-> pos_out0 == 16'h0000 && vel_out0 == 16'h0000
                      && pos_out1 == 16'h0000 && vel_out1 == 16'h0000)
        else $error("data words nonzero while idle");

    a_init_clear: assert property (@(posedge clk) disable iff (rst)
        take_cmd && state_q == rms_pkg::RMS_IDLE |=> !init_flag ##1 !init_flag)
        else $error("init flag not cleared by first command");

    a_one_mode: assert property (@(posedge clk) disable iff (rst)
        state_q == rms_pkg::RMS_RUN |-> $onehot(mode_bits))
        else $error("mode bits not one-hot");

    a_net_off: assert property (@(posedge clk) disable iff (rst)
        stack_addr != '0 |-> !net_enable)
        else $error("network enabled at nonzero address");

    a_cfg_reset: assert property (@(posedge clk) disable iff (rst)
        ce && cfg_write && state_q == rms_pkg::RMS_RUN |=> full_scale == 16'h0400
            && !dual_sel && pos_offset0 == 16'h0000 && align_offset == 16'h0000)
        else $error("configuration change did not restore defaults");

    a_foreign_aln: assert property (@(posedge clk) disable iff (rst)
        ce && set_write && set_dual_foreign && !cfg_write && state_q == rms_pkg::RMS_RUN
            |=> align_offset == 16'h0000 && !aln_v_q ##1 !meas_run_q)
        else $error("foreign dual setup did not force realignment");

    a_cmd_idle: assert property (@(posedge clk) disable iff (rst)
        state_q != rms_pkg::RMS_RUN |-> (!meas_run_q && !$onehot(mode_bits)) || init_flag
            || state_q == rms_pkg::RMS_INIT_DONE)
        else $error("mode entered before first command");

endmodule
`default_nettype wire

// File: tb/rms_host_model.sv
// host controller model: issues mode commands and alignment completion
`timescale 1ns/1ps
`default_nettype none

module rms_host_model (
    input wire logic clk,
    output logic cmd_valid,
    output logic [2:0] cmd_code,
    output logic align_done
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd_code = 3'h7;
        align_done = 1'b0;
    end

    // ==========================================================
    // command held for exactly one edge
    // idle code is inverted so a stale code never repeats the last command sent
    task automatic send(input logic [2:0] code);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_code <= ~code;
    endtask

    // re-alignment after the offset was cleared
    task automatic realign();
        @(posedge clk);
        align_done <= 1'b1;
        @(posedge clk);
        align_done <= 1'b0;
    endtask
endmodule

`default_nettype wire

// File: tb/rms_seq_tb_top.sv
// self-checking bench for the resolver mode sequencer
`timescale 1ns/1ps
`default_nettype none

module rms_seq_tb_top;
    typedef struct packed {logic [4:0] mode; logic init;} rms_note_s;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [4:0] addr_sw = 5'h00;
    logic has_net = 1'b1;
    logic [1:0] nv_cal_ok = 2'h3;
    logic [1:0] nv_cfg_ok = 2'h3;
    logic [1:0] nv_set_ok = 2'h3;
    logic nv_aln_ok = 1'b1;
    logic selfcheck_ok = 1'b1;
    logic cfg_write = 1'b0;
    logic set_write = 1'b0;
    logic set_dual_foreign = 1'b0;
    logic [15:0] set_full_scale = 16'h0400;
    logic [1:0] meas_ch_en = 2'h3;
    logic [15:0] pos_in0 = 16'h0000, pos_in1 = 16'h0000;
    logic [15:0] vel_in0 = 16'h0000, vel_in1 = 16'h0000;
    logic hold_in = 1'b0;
    logic cmd_valid, align_done, cmd_accept, init_flag, net_enable, dual_sel;
    logic [2:0] cmd_code;
    logic [4:0] mode_bits, ch0_status, ch1_status, stack_addr;
    logic [15:0] pos_out0, pos_out1, vel_out0, vel_out1;
    logic [15:0] full_scale, align_offset, pos_offset0, pos_offset1, fs;
    int miscompares = 0;
    int check_count = 0;
    rms_note_s notes[$];
    rms_note_s note_q;
    logic [4:0] code_exp [6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h10};

    rms_seq dut_u (.clk, .rst, .ce, .addr_sw, .has_net, .nv_cal_ok, .nv_cfg_ok, .nv_set_ok,
        .nv_aln_ok, .selfcheck_ok, .cmd_valid, .cmd_code, .cfg_write, .set_write,
        .set_dual_foreign, .set_full_scale, .align_done, .meas_ch_en, .pos_in0, .pos_in1,
        .vel_in0, .vel_in1, .cmd_accept, .init_flag, .mode_bits, .ch0_status, .ch1_status,
        .pos_out0, .pos_out1, .vel_out0, .vel_out1, .stack_addr, .net_enable, .dual_sel,
        .full_scale, .align_offset, .pos_offset0, .pos_offset1);

    rms_host_model host_u (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .align_done(align_done));

    always #25 clk = ~clk;

    // raw measurement words change every cycle unless a data check holds them
    always @(posedge clk)
        if (!hold_in)
        begin
            pos_in0 <= 16'($urandom);
            pos_in1 <= 16'($urandom);
            vel_in0 <= 16'($urandom);
            vel_in1 <= 16'($urandom);
        end

    // ==========================================================
    // comparison and closing
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // an accept with no note pending means a command was taken too early
    always @(posedge clk)
        if (cmd_accept === 1'b1)
        begin
            if (notes.size() == 0)
                check(16'h0001, 16'h0000, "unexpected accept");
            else
            begin
                note_q = notes.pop_front();
                check(16'(mode_bits), 16'(note_q.mode), "mode bits");
                check(16'(init_flag), 16'(note_q.init), "init flag");
            end
        end

    // ==========================================================
    // stimulus tasks
    task automatic cmd(input logic [2:0] code, input logic [4:0] exp_mode);
        notes.push_back('{exp_mode, 1'b0});
        host_u.send(code);
        repeat (3) @(posedge clk);
    endtask

    task automatic power_up(input logic [4:0] sw, input logic [1:0] set_ok, input logic [4:0] exp);
        int ch_at;
        int mod_at;
        int n;
        ch_at = -1;
        mod_at = -1;
        n = 0;
        @(posedge clk);
        rst <= 1'b1;
        addr_sw <= sw;
        nv_set_ok <= set_ok;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        host_u.send(3'h4);
        while (init_flag !== 1'b1 && n < 60)
        begin
            @(posedge clk);
            n++;
            if (ch_at < 0 && ch0_status !== 5'h00)
                ch_at = n;
            if (mod_at < 0 && mode_bits !== 5'h00)
                mod_at = n;
        end
        check(16'(init_flag), 16'h0001, "init after power-up");
        check(16'(ch_at < mod_at && ch_at > 0), 16'h0001, "status order");
        check(16'(mod_at < n), 16'h0001, "init not last");
        check(16'(mode_bits), 16'(exp), "power-up mode");
        check(16'(ch0_status[2:0]), {13'h0, set_ok[0], 2'h3}, "channel status");
        check(16'(ch1_status[2:0]), {13'h0, set_ok[1], 2'h3}, "channel 1 status");
        check(16'(stack_addr), 16'(sw), "stack address");
        check(16'(net_enable), 16'(sw == 5'h00 && has_net), "net enable");
        check(full_scale, 16'h0400, "default scale");
        addr_sw <= (sw == 5'h00) ? 5'h01 : 5'h00;
        repeat (8) @(posedge clk);
        check(16'(stack_addr), 16'(sw), "address relatch");
        check(pos_out0 | pos_out1 | vel_out0 | vel_out1, 16'h0000, "idle data");
        check(16'(init_flag), 16'h0001, "idle keeps init");
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        void'($urandom(32'h953e2dc3));
        power_up(5'h00, 2'h3, 5'h10);
        // clock enable low: a command must not be taken
        ce <= 1'b0;
        host_u.send(3'h4);
        repeat (2) @(posedge clk);
        ce <= 1'b1;
        @(posedge clk);
        check(16'(init_flag), 16'h0001, "frozen command ignored");
        check(16'(mode_bits), 16'h0010, "frozen mode kept");
        cmd(3'h4, 5'h10);
        meas_ch_en <= 2'h1;
        hold_in <= 1'b1;
        repeat (4) @(posedge clk);
        check(pos_out0, pos_in0, "position ch0");
        check(vel_out0, vel_in0, "velocity ch0");
        check(pos_out1 | vel_out1, 16'h0000, "disabled ch1");
        check(16'(ch0_status[4]), 16'h0001, "ch0 measuring");
        check(16'(ch1_status[4]), 16'h0000, "ch1 not measuring");
        hold_in <= 1'b0;
        fs = 16'($urandom);
        set_dual_foreign <= 1'b1;
        set_full_scale <= fs;
        set_write <= 1'b1;
        @(posedge clk);
        set_write <= 1'b0;
        repeat (2) @(posedge clk);
        check(16'(dual_sel), 16'h0001, "dual select");
        check(full_scale, fs, "setup scale");
        check(align_offset, 16'h0000, "align offset");
        check(pos_offset0 | pos_offset1, 16'h0000, "setup offsets");
        cmd(3'h4, 5'h08);
        host_u.realign();
        cmd(3'h4, 5'h10);
        cfg_write <= 1'b1;
        @(posedge clk);
        cfg_write <= 1'b0;
        repeat (2) @(posedge clk);
        check(full_scale, 16'h0400, "config scale");
        check(16'(dual_sel), 16'h0000, "config single");
        check(pos_offset0 | pos_offset1, 16'h0000, "config offsets");
        for (int i = 0; i < 6; i++)
            cmd(3'(i), code_exp[i]);
        power_up(5'h04, 2'h0, 5'h04);
        cmd(3'h4, 5'h04);
        check(pos_out0 | pos_out1 | vel_out0 | vel_out1, 16'h0000, "no setup data");
        check(16'(notes.size()), 16'h0000, "missing accepts");
        tally_and_finish();
    end

    // hang guard: the sequence needs well under a thousand cycles
    initial
    begin
        repeat (4000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
